// >>> rtl/dsw_consts.svh
// Constants for the drive status word and serial link supervision block.
// Assumes inclusion by bare name from the design files only.
`ifndef DSW_CONSTS_SVH
`define DSW_CONSTS_SVH

`define DSW_CLK_HZ 20000000
`define DSW_TIME_UNIT_MS 1
`define DSW_MS_CYCLES ((`DSW_CLK_HZ / 1000) * `DSW_TIME_UNIT_MS)
`define DSW_BAUD_DIV(b) ((`DSW_CLK_HZ + ((b) / 2)) / (b))

// Status word bit positions
`define DSW_B_READY_START 0
`define DSW_B_READY 1
`define DSW_B_OP_ENABLED 2
`define DSW_B_FAULT 3
`define DSW_B_NO_COAST 4
`define DSW_B_NO_QUICK 5
`define DSW_B_LOCKOUT 6
`define DSW_B_ALARM 7
`define DSW_B_SPEED_BAND 8
`define DSW_B_MASTER_REQ 9
`define DSW_B_SPEED_REACHED 10
`define DSW_B_TORQUE_OK 11
`define DSW_B_SPARE 12
`define DSW_B_MOTOR_TEMP_N 13
`define DSW_B_CLOCKWISE 14
`define DSW_B_INV_OVLD_N 15

// Control word bit positions
`define DSW_C_ON 0
`define DSW_C_NO_COAST 1
`define DSW_C_NO_QUICK 2
`define DSW_C_ENABLE_OP 3
`define DSW_C_ACK 7

// Setting indexes on the parameter port
`define DSW_I_BAUD 5'h00
`define DSW_I_ADDR 5'h01
`define DSW_I_PZD 5'h02
`define DSW_I_PKW 5'h03
`define DSW_I_T_PROC 5'h04
`define DSW_I_T_CHAR 5'h05
`define DSW_I_T_DEAD 5'h06
`define DSW_I_PROTO 5'h07
`define DSW_I_PARITY 5'h08
`define DSW_I_TIMEOUT 5'h09
`define DSW_I_STATUS 5'h0a
`define DSW_I_EFF_ADDR 5'h0b
`define DSW_I_CNT_BASE 2'h2

// Reset values and ranges
`define DSW_BAUD_MIN 16'h0004
`define DSW_BAUD_MAX 16'h000d
`define DSW_BAUD_DEF 4'h8
`define DSW_ADDR_DEF 16'h0000
`define DSW_PZD_DEF 16'h0002
`define DSW_PKW_DEF 16'h007f
`define DSW_T_PROC_DEF 16'h03e8
`define DSW_T_CHAR_DEF 16'h0000
`define DSW_T_DEAD_DEF 16'h0000
`define DSW_PROTO_VENDOR 16'h0001
`define DSW_PROTO_DEF 16'h0001
`define DSW_PARITY_MAX 16'h0002
`define DSW_PARITY_DEF 2'h2
`define DSW_TIMEOUT_DEF 16'h0000
`define DSW_ERR_REJECTED 3'h1

`endif

// >>> rtl/dsw_pkg.sv
// Types shared by the drive status word block and its output buffer.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package dsw_pkg;
	typedef logic [15:0] dsw_word_t;
	typedef enum logic [1:0] {
		DSW_PAR_NONE = 2'b00,
		DSW_PAR_ODD = 2'b01,
		DSW_PAR_EVEN = 2'b10
	} dsw_parity_e;
endpackage
`default_nettype wire

// >>> rtl/dsw_skid_buffer.sv
// Two-entry buffer for status words bound for the telegram transmitter.
// Assumes an asynchronous active-low reset already released cleanly.
`default_nettype none
module dsw_skid_buffer
	import dsw_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	dsw_stream_if.snk upstream,
	dsw_stream_if.src downstream
);
	dsw_word_t head;
	dsw_word_t tail;
	logic headValid;
	logic tailValid;
	logic notFull;
	logic push;
	logic pop;

	assign push = upstream.valid & notFull;
	assign pop = headValid & downstream.ready;
	assign upstream.ready = notFull;
	assign downstream.valid = headValid;
	assign downstream.data = head;

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			head <= '0;
			tail <= '0;
			headValid <= 1'b0;
			tailValid <= 1'b0;
			notFull <= 1'b1;
		end
		else if (tailValid)
		begin
			if (pop)
			begin
				head <= tail;
				tailValid <= 1'b0;
				notFull <= 1'b1;
			end
		end
		else if (headValid)
		begin
			if (push && pop)
				head <= upstream.data;
			else if (push)
			begin
				tail <= upstream.data;
				tailValid <= 1'b1;
				notFull <= 1'b0;
			end
			else if (pop)
				headValid <= 1'b0;
		end
		else if (push)
		begin
			head <= upstream.data;
			headValid <= 1'b1;
		end
	end
endmodule
`default_nettype wire

// >>> rtl/dsw_status_link.sv
// Drive status word assembly and serial link settings and supervision.
// Assumes drive inputs come from logic on clk; address switches are pins.
// Function
// - Bit 0 set when powered, initialised and pulses locked.
// - Bit 1 set when on command active and no fault.
// - Bit 2 set while enable-operation bit set and motor follows setpoint.
// - Bit 3 holds a fault until acknowledged by control bit 7.
// - Bit 4 shows no coast stop, bit 5 no quick stop.
// - Bit 6 shows switch-on lockout, left by ramp stop alone (control bit 0 low).
// - Bit 7 shows any alarm; alarm needs no acknowledge.
// - Bit 8 set while speed error lies inside tolerance band.
// - Bit 9 asks the automation system to take control.
// - Bit 10 set when actual speed reaches comparison speed.
// - Bit 11 set while current or torque below its limit.
// - Bit 13 low while motor over-temperature alarm present.
// - Bit 15 low while inverter thermal overload alarm present.
// - Bit 14 set for positive speed, clear for negative.
// - Baud codes 4 to 13 map to ten rates, default code 8.
// - Software address used only at switch zero, taken at reset.
// - Process word count defaults 2, parameter count 127 variable.
// - Timing set: processing 1000 ms, character and dead time 0 ms.
// - Eight read-only link counters for telegram outcomes and errors.
// - Protocol setting 1 selects the vendor serial protocol.
// - Parity 0 none, 1 odd, 2 even, default even.
// - Telegram timeout monitor off at 0, else supervises gaps.
`include "dsw_consts.svh"
`default_nettype none
module dsw_status_link
	import dsw_pkg::*;
#(
	parameter int MS_CYCLES = `DSW_MS_CYCLES,
	parameter int CNT_W = 16
)
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic [15:0] driveControlWord,
	input wire logic powerOk,
	input wire logic initDone,
	input wire logic pulsesLocked,
	input wire logic followSetpoint,
	input wire logic faultPresent,
	input wire logic alarmActive,
	input wire logic masterControlRequest,
	input wire logic signed [15:0] speedSetpoint,
	input wire logic signed [15:0] speedActual,
	input wire logic [15:0] speedTolerance,
	input wire logic signed [15:0] compareSpeed,
	input wire logic [15:0] currentActual,
	input wire logic [15:0] currentLimit,
	input wire logic motorOverTemp,
	input wire logic inverterOverload,
	input wire logic spareRouteEn,
	input wire logic spareSource,
	input wire logic [6:0] addressSwitches,
	input wire logic telegramGood,
	input wire logic telegramError,
	input wire logic [2:0] telegramErrorCode,
	input wire logic paramWe,
	input wire logic paramRe,
	input wire logic [4:0] paramIndex,
	input wire logic [15:0] paramWrData,
	input wire logic statusReady,
	output logic [15:0] driveStatusWord,
	output logic statusValid,
	output logic [15:0] statusData,
	output logic statusInReady,
	output logic [15:0] baudDivisor,
	output logic [15:0] nodeAddress,
	output logic [15:0] processWordCount,
	output logic [15:0] parameterChannelCount,
	output logic [15:0] maxProcessTime,
	output logic [15:0] charDelayTime,
	output logic [15:0] deadTime,
	output logic vendorProtocolEn,
	output logic [1:0] paritySelect,
	output logic timeoutFlag,
	output logic [15:0] paramRdData,
	output logic paramRdValid,
	output logic paramWrErr
);
	if (MS_CYCLES < 2 || CNT_W < 1 || CNT_W > 16)
	begin
		$error("dsw_status_link: unsupported MS_CYCLES or CNT_W");
	end

	logic [1:0] rstSync;
	logic rstnInt;
	logic [6:0] swMeta;
	logic [6:0] swSync;
	logic [6:0] swPrev;
	logic [2:0] swFill;
	logic addrTaken;
	logic [3:0] baudSelect;
	logic [15:0] softAddress;
	logic [15:0] telegramTimeout;
	logic [15:0] next_statusWord;
	logic ackPrev;
	logic ackEdge;
	logic faultLatched;
	logic lockout;
	logic [16:0] speedDiff;
	logic [16:0] speedErr;
	logic [31:0] msCount;
	logic [15:0] elapsedMs;
	logic [CNT_W-1:0] linkCount [8];
	logic [15:0] next_rdData;
	logic wrValid;
	dsw_stream_if toBuf ();
	dsw_stream_if fromBuf ();

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			rstSync <= 2'b00;
		else
			rstSync <= {rstSync[0], 1'b1};
	end
	assign rstnInt = rstSync[1];

	// Address switches are pins: two stages before use
	always_ff @(posedge clk or negedge rstnInt)
	begin
		if (!rstnInt)
		begin
			swMeta <= '0;
			swSync <= '0;
			swPrev <= '0;
			swFill <= '0;
		end
		else
		begin
			swMeta <= addressSwitches;
			swSync <= swMeta;
			swPrev <= swSync;
			swFill <= {swFill[1:0], 1'b1};
		end
	end

	assign ackEdge = driveControlWord[`DSW_C_ACK] & ~ackPrev;

	// Set wins over acknowledge so a fresh fault is never lost
	always_ff @(posedge clk or negedge rstnInt)
	begin
		if (!rstnInt)
		begin
			ackPrev <= 1'b0;
			faultLatched <= 1'b0;
		end
		else
		begin
			ackPrev <= driveControlWord[`DSW_C_ACK];
			faultLatched <= faultPresent | (faultLatched & ~ackEdge);
		end
	end

	always_ff @(posedge clk or negedge rstnInt)
	begin
		if (!rstnInt)
			lockout <= 1'b0;
		else if (ackEdge && faultLatched && !faultPresent && driveControlWord[`DSW_C_ON])
			lockout <= 1'b1;
		else if (!driveControlWord[`DSW_C_ON])
			lockout <= 1'b0;
	end

	assign speedDiff = 17'(speedSetpoint) - 17'(speedActual);
	assign speedErr = speedDiff[16] ? 17'(-speedDiff) : speedDiff;

	always_comb
	begin
		next_statusWord = '0;
		next_statusWord[`DSW_B_READY_START] = powerOk & initDone & pulsesLocked;
		next_statusWord[`DSW_B_READY] = driveControlWord[`DSW_C_ON] & ~faultLatched;
		next_statusWord[`DSW_B_OP_ENABLED] = driveControlWord[`DSW_C_ENABLE_OP]
			& followSetpoint;
		next_statusWord[`DSW_B_FAULT] = faultLatched;
		next_statusWord[`DSW_B_NO_COAST] = driveControlWord[`DSW_C_NO_COAST];
		next_statusWord[`DSW_B_NO_QUICK] = driveControlWord[`DSW_C_NO_QUICK];
		next_statusWord[`DSW_B_LOCKOUT] = lockout;
		next_statusWord[`DSW_B_ALARM] = alarmActive;
		next_statusWord[`DSW_B_SPEED_BAND] = speedErr <= {1'b0, speedTolerance};
		next_statusWord[`DSW_B_MASTER_REQ] = masterControlRequest;
		next_statusWord[`DSW_B_SPEED_REACHED] = speedActual >= compareSpeed;
		next_statusWord[`DSW_B_TORQUE_OK] = currentActual < currentLimit;
		next_statusWord[`DSW_B_SPARE] = spareRouteEn & spareSource;
		next_statusWord[`DSW_B_MOTOR_TEMP_N] = ~motorOverTemp;
		next_statusWord[`DSW_B_CLOCKWISE] = speedActual > 16'sh0000;
		next_statusWord[`DSW_B_INV_OVLD_N] = ~inverterOverload;
	end

	always_ff @(posedge clk or negedge rstnInt)
	begin
		if (!rstnInt)
			driveStatusWord <= '0;
		else
			driveStatusWord <= next_statusWord;
	end

	// Out-of-range setting writes are refused and flagged
	always_comb
	begin
		wrValid = 1'b1;
		unique case (paramIndex)
			`DSW_I_BAUD: wrValid = paramWrData >= `DSW_BAUD_MIN
				&& paramWrData <= `DSW_BAUD_MAX;
			`DSW_I_PARITY: wrValid = paramWrData <= `DSW_PARITY_MAX;
			`DSW_I_ADDR, `DSW_I_PZD, `DSW_I_PKW, `DSW_I_T_PROC, `DSW_I_T_CHAR,
			`DSW_I_T_DEAD, `DSW_I_PROTO, `DSW_I_TIMEOUT: wrValid = 1'b1;
			default: wrValid = 1'b0;
		endcase
	end

	always_ff @(posedge clk or negedge rstnInt)
	begin
		if (!rstnInt)
		begin
			baudSelect <= `DSW_BAUD_DEF;
			softAddress <= `DSW_ADDR_DEF;
			processWordCount <= `DSW_PZD_DEF;
			parameterChannelCount <= `DSW_PKW_DEF;
			maxProcessTime <= `DSW_T_PROC_DEF;
			charDelayTime <= `DSW_T_CHAR_DEF;
			deadTime <= `DSW_T_DEAD_DEF;
			vendorProtocolEn <= `DSW_PROTO_DEF == `DSW_PROTO_VENDOR;
			paritySelect <= `DSW_PARITY_DEF;
			telegramTimeout <= `DSW_TIMEOUT_DEF;
			paramWrErr <= 1'b0;
		end
		else
		begin
			paramWrErr <= paramWe & ~wrValid;
			if (paramWe && wrValid)
			begin
				unique case (paramIndex)
					`DSW_I_BAUD: baudSelect <= paramWrData[3:0];
					`DSW_I_ADDR: softAddress <= paramWrData;
					`DSW_I_PZD: processWordCount <= paramWrData;
					`DSW_I_PKW: parameterChannelCount <= paramWrData;
					`DSW_I_T_PROC: maxProcessTime <= paramWrData;
					`DSW_I_T_CHAR: charDelayTime <= paramWrData;
					`DSW_I_T_DEAD: deadTime <= paramWrData;
					`DSW_I_PROTO: vendorProtocolEn <= paramWrData == `DSW_PROTO_VENDOR;
					`DSW_I_PARITY: paritySelect <= paramWrData[1:0];
					`DSW_I_TIMEOUT: telegramTimeout <= paramWrData;
					default: telegramTimeout <= telegramTimeout;
				endcase
			end
		end
	end

	always_ff @(posedge clk or negedge rstnInt)
	begin
		if (!rstnInt)
			baudDivisor <= 16'(`DSW_BAUD_DIV(38400));
		else
		begin
			unique case (baudSelect)
				4'h4: baudDivisor <= 16'(`DSW_BAUD_DIV(2400));
				4'h5: baudDivisor <= 16'(`DSW_BAUD_DIV(4800));
				4'h6: baudDivisor <= 16'(`DSW_BAUD_DIV(9600));
				4'h7: baudDivisor <= 16'(`DSW_BAUD_DIV(19200));
				4'h8: baudDivisor <= 16'(`DSW_BAUD_DIV(38400));
				4'h9: baudDivisor <= 16'(`DSW_BAUD_DIV(57600));
				4'ha: baudDivisor <= 16'(`DSW_BAUD_DIV(76800));
				4'hb: baudDivisor <= 16'(`DSW_BAUD_DIV(93750));
				4'hc: baudDivisor <= 16'(`DSW_BAUD_DIV(115200));
				4'hd: baudDivisor <= 16'(`DSW_BAUD_DIV(187500));
				default: baudDivisor <= 16'(`DSW_BAUD_DIV(38400));
			endcase
		end
	end

	// Address is frozen once after reset; later writes are lost, as the next reset restores softAddress to its default
	always_ff @(posedge clk or negedge rstnInt)
	begin
		if (!rstnInt)
		begin
			addrTaken <= 1'b0;
			nodeAddress <= '0;
		end
		// Waits until every stage holds a sample taken after reset
		else if (!addrTaken && swFill[2] && swSync == swPrev)
		begin
			addrTaken <= 1'b1;
			nodeAddress <= (swSync == 7'h00) ? softAddress : {9'h000, swSync};
		end
	end

	always_ff @(posedge clk or negedge rstnInt)
	begin
		if (!rstnInt)
		begin
			for (int i = 0; i < 8; i++)
				linkCount[i] <= '0;
		end
		else
		begin
			if (telegramGood)
				linkCount[0] <= linkCount[0] + 1'b1;
			if (telegramError && telegramErrorCode != 3'h0)
				linkCount[telegramErrorCode] <= linkCount[telegramErrorCode] + 1'b1;
			else if (telegramGood && !statusInReady)
				linkCount[`DSW_ERR_REJECTED] <= linkCount[`DSW_ERR_REJECTED] + 1'b1;
		end
	end

	// Millisecond base and gap supervision; saturating so a long gap stays flagged
	always_ff @(posedge clk or negedge rstnInt)
	begin
		if (!rstnInt)
		begin
			msCount <= '0;
			elapsedMs <= '0;
			timeoutFlag <= 1'b0;
		end
		else
		begin
			msCount <= (msCount == 32'(MS_CYCLES - 1)) ? '0 : msCount + 1'b1;
			if (telegramGood)
			begin
				elapsedMs <= '0;
				msCount <= '0;
			end
			else if (msCount == 32'(MS_CYCLES - 1) && elapsedMs != 16'hffff)
				elapsedMs <= elapsedMs + 1'b1;
			if (telegramTimeout != 16'h0000 && elapsedMs >= telegramTimeout)
				timeoutFlag <= 1'b1;
			else if (telegramGood || telegramTimeout == 16'h0000)
				timeoutFlag <= 1'b0;
		end
	end

	always_comb
	begin
		next_rdData = '0;
		if (paramIndex[4:3] == `DSW_I_CNT_BASE)
			next_rdData = 16'(linkCount[paramIndex[2:0]]);
		else
		begin
			case (paramIndex)
				`DSW_I_BAUD: next_rdData = {12'h000, baudSelect};
				`DSW_I_ADDR: next_rdData = softAddress;
				`DSW_I_PZD: next_rdData = processWordCount;
				`DSW_I_PKW: next_rdData = parameterChannelCount;
				`DSW_I_T_PROC: next_rdData = maxProcessTime;
				`DSW_I_T_CHAR: next_rdData = charDelayTime;
				`DSW_I_T_DEAD: next_rdData = deadTime;
				`DSW_I_PROTO: next_rdData = {15'h0000, vendorProtocolEn};
				`DSW_I_PARITY: next_rdData = {14'h0000, paritySelect};
				`DSW_I_TIMEOUT: next_rdData = telegramTimeout;
				`DSW_I_STATUS: next_rdData = driveStatusWord;
				`DSW_I_EFF_ADDR: next_rdData = nodeAddress;
				default: next_rdData = '0;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rstnInt)
	begin
		if (!rstnInt)
		begin
			paramRdData <= '0;
			paramRdValid <= 1'b0;
		end
		else
		begin
			paramRdValid <= paramRe;
			if (paramRe)
				paramRdData <= next_rdData;
		end
	end

	// Each good telegram queues the reply status word while the buffer has room
	assign toBuf.valid = telegramGood;
	assign toBuf.data = driveStatusWord;
	assign fromBuf.ready = statusReady;
	assign statusValid = fromBuf.valid;
	assign statusData = fromBuf.data;
	assign statusInReady = toBuf.ready;

	dsw_skid_buffer replyBuffer (
		.clk(clk),
		.rstn(rstnInt),
		.upstream(toBuf),
		.downstream(fromBuf)
	);

	default clocking @(posedge clk); endclocking
	default disable iff (!rstnInt);

	sequence s_ack_edge;
		faultLatched && !faultPresent && ackEdge;
	endsequence
	sequence s_cleared;
		!faultLatched ##1 !driveStatusWord[`DSW_B_FAULT];
	endsequence

	a_fault_sticky: assert property (faultPresent |=> faultLatched ##1 driveStatusWord[3])
		else $error("fault bit did not set");
	a_fault_ack: assert property (s_ack_edge ##1 !faultPresent |-> s_cleared)
		else $error("acknowledge did not clear fault");
	a_ready_start: assert property ($past(rstnInt)
		|-> driveStatusWord[`DSW_B_READY_START] == $past(powerOk && initDone && pulsesLocked))
		else $error("ready-to-start bit wrong");
	a_lockout_exit: assert property (!driveControlWord[0] |=> !lockout)
		else $error("lockout not left on ramp stop");
	a_temp_low: assert property (motorOverTemp |=> !driveStatusWord[13])
		else $error("motor temperature bit not low");
	a_spare_zero: assert property (!spareRouteEn |=> !driveStatusWord[12])
		else $error("spare bit not zero");
	a_baud_refused: assert property (paramWe && paramIndex == `DSW_I_BAUD
		&& paramWrData > `DSW_BAUD_MAX |=> $stable(baudSelect) && paramWrErr)
		else $error("bad baud code accepted");
	a_parity_range: assert property (paritySelect != 2'b11)
		else $error("illegal parity setting");
	a_addr_frozen: assert property (addrTaken |=> $stable(nodeAddress))
		else $error("node address changed after reset");
	a_timeout_off: assert property (telegramTimeout == 16'h0000 |=> !timeoutFlag)
		else $error("timeout flag while monitor off");
	a_good_count: assert property (telegramGood
		|=> linkCount[0] == $past(linkCount[0]) + 1'b1)
		else $error("good telegram not counted");
	a_reply_queued: assert property (telegramGood && statusInReady |-> ##[1:2] statusValid)
		else $error("reply word not queued");
endmodule
`default_nettype wire

// >>> rtl/dsw_stream_if.sv
// Valid/ready word stream between the status logic and its buffer.
// Assumes both ends share one clock.
`default_nettype none
interface dsw_stream_if;
	import dsw_pkg::*;
	logic valid;
	logic ready;
	dsw_word_t data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// >>> verification/dsw_master_model.sv
// Automation master model: takes status words from the buffer head.
// Assumes the valid/ready stream on clk; the bench sets stall.
`default_nettype none
module dsw_master_model
(
	input wire logic clk,
	input wire logic stall,
	input wire logic statusValid,
	input wire logic [15:0] statusData,
	output logic statusReady,
	output logic [15:0] lastWord
);
	timeunit 1ns;
	timeprecision 1ns;
	// Ready stays low while stalled so the buffer must hold its words
	assign statusReady = !stall;
	always @(posedge clk)
	begin
		if (statusValid && statusReady)
			lastWord <= statusData;
	end
endmodule
`default_nettype wire

// >>> verification/tb_drive_status_word_serial_link.sv
// Self-checking bench for the status word and link settings block.
// Assumes the design files and the master model are compiled first.
`default_nettype none
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin miscompares++; \
	$display("[FAIL] %s exp %h got %h", nm, ex, got); end end
module tb_drive_status_word_serial_link;
	timeunit 1ns;
	timeprecision 1ns;
	// Flags: power, init, locked, follow, alarm, master, motorHot, invHot, spareEn, spareSrc
	typedef struct { logic [15:0] c; logic [9:0] f; logic [15:0] s, a, t, m, i, l, e; } dsw_row_s;
	logic clk = 0, rstn = 0, stall = 0, fault = 0, good = 0, terr = 0, we = 0, re = 0;
	logic [2:0] ecode = '0;
	logic [4:0] idx = '0;
	logic [6:0] sw = '0;
	logic [9:0] fl;
	logic [15:0] ctl, tol, ca, cl, wd = '0, lastWord, dsw, sdat, bdiv, naddr, pwc, pcc;
	logic [15:0] tproc, tchar, tdead, rdat;
	logic signed [15:0] sp, sa, cmp;
	logic srdy, sval, sinr, vpe, tof, rval, werr;
	logic [1:0] par;
	int checked = 0, miscompares = 0, cycles = 0;
	dsw_row_s rows [4] = '{
		'{16'h0000, 10'h000, 16'h0000, 16'h0000, 16'h000a, 16'h0064, 16'h0000, 16'h0000, 16'ha100},
		'{16'h000f, 10'h3ff, 16'h01f4, 16'h01f4, 16'h000a, 16'h01f4, 16'h0005, 16'h0006, 16'h5fb7},
		'{16'h0009, 10'h242, 16'hff9c, 16'hff88, 16'h000a, 16'hff7e, 16'h000a, 16'h0005, 16'ha406},
		'{16'h0006, 10'h380, 16'h03e8, 16'h0001, 16'h07d0, 16'h0002, 16'h0000, 16'h0001, 16'he931}};

	dsw_status_link #(.MS_CYCLES(10), .CNT_W(16)) i_dut (.clk(clk), .rstn(rstn),
		.driveControlWord(ctl), .powerOk(fl[9]), .initDone(fl[8]), .pulsesLocked(fl[7]),
		.followSetpoint(fl[6]), .faultPresent(fault), .alarmActive(fl[5]),
		.masterControlRequest(fl[4]), .speedSetpoint(sp), .speedActual(sa),
		.speedTolerance(tol), .compareSpeed(cmp), .currentActual(ca), .currentLimit(cl),
		.motorOverTemp(fl[3]), .inverterOverload(fl[2]), .spareRouteEn(fl[1]),
		.spareSource(fl[0]), .addressSwitches(sw), .telegramGood(good),
		.telegramError(terr), .telegramErrorCode(ecode), .paramWe(we), .paramRe(re),
		.paramIndex(idx), .paramWrData(wd), .statusReady(srdy), .driveStatusWord(dsw),
		.statusValid(sval), .statusData(sdat), .statusInReady(sinr), .baudDivisor(bdiv),
		.nodeAddress(naddr), .processWordCount(pwc), .parameterChannelCount(pcc),
		.maxProcessTime(tproc), .charDelayTime(tchar), .deadTime(tdead),
		.vendorProtocolEn(vpe), .paritySelect(par), .timeoutFlag(tof), .paramRdData(rdat),
		.paramRdValid(rval), .paramWrErr(werr));
	dsw_master_model i_plc (.clk(clk), .stall(stall), .statusValid(sval), .statusData(sdat),
		.statusReady(srdy), .lastWord(lastWord));

	always #25 clk = ~clk;

	task automatic complete_run();
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// Hang guard, far above the few hundred cycles the run needs
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			miscompares++;
			complete_run();
		end
	end

	// Inputs always change one step after the rising edge
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic apply(input dsw_row_s r);
		{ctl, fl, sp, sa, tol, cmp, ca, cl} = {r.c, r.f, r.s, r.a, r.t, r.m, r.i, r.l};
	endtask

	// Refusal shows right after the write edge and is cleared one cycle later; both samples are ORed
	task automatic wr(input logic [4:0] i, input logic [15:0] d, output logic e);
		{we, idx, wd} = {1'b1, i, d};
		step(1);
		we = 1'b0;
		e = werr;
		step(1);
		e = e | werr;
		step(1);
	endtask

	task automatic rd(input logic [4:0] i, output logic [15:0] d);
		{re, idx} = {1'b1, i};
		step(1);
		re = 1'b0;
		`CHK("rdValid", 1'b1, rval)
		d = rdat;
		step(1);
	endtask

	task automatic pulse(input logic g, input logic [2:0] c);
		{good, terr, ecode} = {g, !g, c};
		step(1);
		{good, terr} = 2'b00;
		step(1);
	endtask

	initial
	begin
		logic [15:0] v;
		logic e;
		static logic [19:0] rates [10] = '{20'h0_0960, 20'h0_12c0, 20'h0_2580, 20'h0_4b00,
			20'h0_9600, 20'h0_e100, 20'h1_2c00, 20'h1_6e36, 20'h1_c200, 20'h2_dc6c};
		apply(rows[0]);
		repeat (20) @(posedge clk);
		#1;
		rstn = 1'b1;
		step(3);
		`CHK("baudDiv", 16'h0209, bdiv)
		rd(5'h00, v);
		`CHK("baudCode", 16'h0008, v)
		`CHK("pzdCount", 16'h0002, pwc)
		`CHK("pkwCount", 16'h007f, pcc)
		`CHK("procTime", 16'h03e8, tproc)
		`CHK("charTime", 16'h0000, tchar)
		`CHK("deadTime", 16'h0000, tdead)
		`CHK("protocol", 1'b1, vpe)
		`CHK("parity", 2'h2, par)
		`CHK("timeout", 1'b0, tof)
		`CHK("address", 16'h0000, naddr)
		$display("test reset done");
		foreach (rows[k])
		begin
			apply(rows[k]);
			step(2);
			`CHK("statusWord", rows[k].e, dsw)
		end
		$display("test rows done");
		pulse(1'b1, 3'h0);
		pulse(1'b1, 3'h0);
		for (int k = 1; k < 8; k++)
			pulse(1'b0, 3'(k));
		for (int k = 0; k < 8; k++)
		begin
			rd(5'(16 + k), v);
			`CHK("linkCount", (k == 0) ? 16'h0002 : 16'h0001, v)
		end
		wr(5'h10, 16'h0005, e);
		`CHK("countWrErr", 1'b1, e)
		$display("test counters done");
		stall = 1'b1;
		apply(rows[0]);
		step(2);
		pulse(1'b1, 3'h0);
		apply(rows[1]);
		step(2);
		pulse(1'b1, 3'h0);
		`CHK("bufFull", 1'b0, sinr)
		pulse(1'b1, 3'h0);
		step(3);
		`CHK("bufHead", 16'ha100, sdat)
		stall = 1'b0;
		step(1);
		`CHK("firstWord", 16'ha100, lastWord)
		step(1);
		`CHK("secondWord", 16'h5fb7, lastWord)
		step(1);
		`CHK("bufEmpty", 1'b0, sval)
		rd(5'h11, v);
		`CHK("rejected", 16'h0002, v)
		$display("test buffer done");
		ctl = 16'h0007;
		fault = 1'b1;
		step(3);
		`CHK("faultSet", 1'b1, dsw[3])
		`CHK("readyOff", 1'b0, dsw[1])
		ctl = 16'h0087;
		step(1);
		ctl = 16'h0007;
		fault = 1'b0;
		step(3);
		`CHK("faultHeld", 1'b1, dsw[3])
		`CHK("noLockout", 1'b0, dsw[6])
		ctl = 16'h0087;
		step(1);
		ctl = 16'h0007;
		step(3);
		`CHK("faultAck", 1'b0, dsw[3])
		`CHK("lockout", 1'b1, dsw[6])
		ctl = 16'h0006;
		step(3);
		`CHK("lockoutOff", 1'b0, dsw[6])
		ctl = 16'h0007;
		step(3);
		`CHK("readyOn", 1'b1, dsw[1])
		$display("test fault done");
		for (int k = 0; k < 10; k++)
		begin
			wr(5'h00, 16'(k + 4), e);
			`CHK("baudDiv", 16'((32'h0131_2d00 + rates[k] / 2) / rates[k]), bdiv)
			`CHK("baudOk", 1'b0, e)
		end
		wr(5'h00, 16'h000e, e);
		`CHK("baudHigh", 1'b1, e)
		wr(5'h00, 16'h0003, e);
		`CHK("baudLow", 1'b1, e)
		`CHK("baudKept", 16'h006b, bdiv)
		for (int k = 0; k < 3; k++)
		begin
			wr(5'h08, 16'(k), e);
			`CHK("parity", 2'(k), par)
		end
		wr(5'h08, 16'h0003, e);
		`CHK("parityErr", 1'b1, e)
		wr(5'h07, 16'h0000, e);
		`CHK("protoOff", 1'b0, vpe)
		wr(5'h02, 16'h0004, e);
		`CHK("pzdCount", 16'h0004, pwc)
		wr(5'h04, 16'h01f4, e);
		`CHK("procTime", 16'h01f4, tproc)
		wr(5'h0a, 16'h0000, e);
		`CHK("statusWrErr", 1'b1, e)
		$display("test settings done");
		step(60);
		`CHK("timeoutOff", 1'b0, tof)
		wr(5'h09, 16'h0003, e);
		`CHK("timeoutStale", 1'b1, tof)
		// The telegram ending a long gap still sees it; only the next one clears
		pulse(1'b1, 3'h0);
		pulse(1'b1, 3'h0);
		step(12);
		`CHK("timeoutEarly", 1'b0, tof)
		step(40);
		`CHK("timeoutSet", 1'b1, tof)
		pulse(1'b1, 3'h0);
		`CHK("timeoutHeld", 1'b1, tof)
		pulse(1'b1, 3'h0);
		`CHK("timeoutClr", 1'b0, tof)
		$display("test timeout done");
		wr(5'h01, 16'h0025, e);
		step(4);
		`CHK("addrDeferred", 16'h0000, naddr)
		sw = 7'h11;
		rstn = 1'b0;
		step(3);
		rstn = 1'b1;
		step(10);
		`CHK("addrSwitch", 16'h0011, naddr)
		`CHK("pzdReset", 16'h0002, pwc)
		$display("test address done");
		complete_run();
	end
endmodule
`default_nettype wire
